// ---- hw/io_port_mode_config.sv ----
// Device end: port configuration registers and per-pin mode selection
`timescale 1ns/1ps
`default_nettype none
module io_port_mode_config
  import io_port_pkg::*;
#(
  parameter io_port_pkg::bus_kind_type BUS_KIND = io_port_pkg::BUS_MUX8,
  parameter io_port_pkg::port_bytes_type LOGIC_IN_MASK = '0,
  parameter io_port_pkg::port_bytes_type LOGIC_OUT_MASK = '0,
  parameter io_port_pkg::port_bytes_type ADDR_IN_MASK = '0,
  parameter logic [7:0] JTAG_E_MASK = 8'h00,
  parameter logic G_HIGH_BYTE = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  io_port_bus_if.device bus,
  input wire io_port_pkg::port_bytes_type pin_in,
  output var io_port_pkg::port_bytes_type pin_out,
  output var io_port_pkg::port_bytes_type pin_oe_n,
  input wire logic [2:0][7:0] logic_out,
  input wire io_port_pkg::port_bytes_type logic_oe,
  output var io_port_pkg::port_bytes_type array_in,
  output var io_port_pkg::port_bytes_type array_addr,
  output var logic [7:0] slew_fast
);
  import io_port_pkg::*;

  typedef struct packed {
    port_bytes_type sync1;
    port_bytes_type sync2;
    port_bytes_type dout;
    port_bytes_type dir;
    port_bytes_type drv;
    port_bytes_type mode;
    port_bytes_type addr_in;
    port_bytes_type pin_out;
    port_bytes_type pin_oe_n;
    logic [15:0] latched_addr;
    logic [7:0] rdata;
    logic [7:0] slew_fast;
  } dev_state_type;

  dev_state_type st;
  dev_state_type next_st;

  // Pins that exist on the port
  function automatic logic [7:0] width_mask(input int p);
    return (p == PORT_D) ? NARROW_PORT : FULL_PORT;
  endfunction

  // Pins left free for general I/O by the programmed configuration
  function automatic logic [7:0] gpio_mask(input int p);
    logic [7:0] m;
    m = width_mask(p) & ~LOGIC_IN_MASK[p] & ~ADDR_IN_MASK[p];
    if (p == PORT_E) begin
      m = m & ~JTAG_E_MASK;
    end
    if (p == PORT_F && BUS_KIND == BUS_NONMUX) begin
      m = 8'h00;
    end
    return m;
  endfunction

  // Pins that can carry latched address bits
  function automatic logic [7:0] addr_cap(input int p);
    logic [7:0] m;
    m = 8'h00;
    if (p == PORT_G) begin
      m = FULL_PORT;
    end else if ((p == PORT_E || p == PORT_F) && BUS_KIND == BUS_MUX8) begin
      m = FULL_PORT;
    end
    return m & gpio_mask(p);
  endfunction

  // Address byte presented on an address-capable port
  function automatic logic [7:0] addr_byte(input int p, input logic [15:0] a);
    logic [7:0] b;
    b = a[7:0];
    if (p == PORT_G && (BUS_KIND == BUS_PAGE || (BUS_KIND == BUS_MUX8 && G_HIGH_BYTE))) begin
      b = a[15:8];
    end
    return b;
  endfunction

  logic sel;
  logic [4:0] grp;
  logic [2:0] port_idx;
  logic in_range;

  assign sel = bus.io_select && (bus.addr[15:8] == IO_SPACE_PAGE);
  assign grp = bus.addr[7:3];
  assign port_idx = bus.addr[2:0];
  assign in_range = (int'(port_idx) < NUM_PORTS);

  always_comb begin
    logic [7:0] ctl_value;
    logic [7:0] val;
    logic [7:0] en;
    logic [7:0] addr_en;
    logic [7:0] ab;
    logic od_ok;
    ctl_value = 8'h00;
    val = 8'h00;
    en = 8'h00;
    addr_en = 8'h00;
    ab = 8'h00;
    od_ok = 1'b0;
    next_st = st;
    next_st.sync1 = pin_in;
    next_st.sync2 = st.sync1;

    // Non-multiplexed hosts hold the address for the whole cycle
    if (bus.address_latch_strobe || BUS_KIND == BUS_NONMUX) begin
      next_st.latched_addr = bus.addr;
    end
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (bus.address_latch_strobe) begin
        next_st.addr_in[p] = st.sync2[p] & ADDR_IN_MASK[p];
      end
    end

    // Register writes land at the edge closing the write strobe
    if (sel && bus.wr && in_range) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (int'(port_idx) == p) begin
          case (grp)
            GRP_DATA_OUT: next_st.dout[p] = bus.wdata & gpio_mask(p);
            GRP_DIRECTION: next_st.dir[p] = bus.wdata & gpio_mask(p);
            GRP_DRIVE: next_st.drv[p] = (p == PORT_F) ? 8'h00 : (bus.wdata & width_mask(p));
            GRP_MODE: next_st.mode[p] = bus.wdata & addr_cap(p);
            default: next_st.dout[p] = st.dout[p];
          endcase
        end
      end
    end

    if (sel && bus.rd) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (int'(port_idx) == p) begin
          case (grp)
            GRP_DATA_IN: ctl_value = st.sync2[p] & gpio_mask(p);
            GRP_DATA_OUT: ctl_value = st.dout[p];
            GRP_DIRECTION: ctl_value = st.dir[p];
            GRP_DRIVE: ctl_value = st.drv[p];
            GRP_MODE: ctl_value = st.mode[p];
            default: ctl_value = 8'h00;
          endcase
        end
      end
      next_st.rdata = ctl_value;
    end

    // Output multiplexer per pin
    for (int p = 0; p < NUM_PORTS; p++) begin
      ab = addr_byte(p, st.latched_addr);
      if (p <= PORT_C) begin
        en = logic_oe[p] & LOGIC_OUT_MASK[p];
        val = (logic_out[p] & en) | (st.dout[p] & ~en);
        en = en | (st.dir[p] & gpio_mask(p));
      end else begin
        addr_en = (logic_oe[p] | (st.dir[p] & st.mode[p])) & addr_cap(p);
        val = (ab & addr_en) | (st.dout[p] & ~addr_en);
        en = addr_en | (st.dir[p] & gpio_mask(p));
      end
      en = en & ~LOGIC_IN_MASK[p] & width_mask(p);
      od_ok = (p != PORT_C) && (p != PORT_F);
      for (int b = 0; b < 8; b++) begin
        if (od_ok && st.drv[p][b]) begin
          next_st.pin_out[p][b] = 1'b0;
          next_st.pin_oe_n[p][b] = ~(en[b] & ~val[b]);
        end else begin
          next_st.pin_out[p][b] = val[b] & en[b];
          next_st.pin_oe_n[p][b] = ~en[b];
        end
      end
    end
    next_st.slew_fast = st.drv[PORT_C];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.pin_oe_n <= {NUM_PORTS{FULL_PORT}};
      st.dout <= {NUM_PORTS{REG_RESET}};
    end else begin
      st <= next_st;
    end
  end

  assign bus.rdata = st.rdata;
  assign pin_out = st.pin_out;
  assign pin_oe_n = st.pin_oe_n;
  assign array_in = st.sync2;
  assign array_addr = st.addr_in;
  assign slew_fast = st.slew_fast;

  // Pins reading as address inputs still feed the arrays through array_in
  // With a non-multiplexed host (BUS_NONMUX), port F data lanes are carried by the bus itself, so its pins stay released

endmodule // io_port_mode_config
`default_nettype wire

// ---- hw/io_port_pkg.sv ----
// Shared constants and types for the configurable I/O port block
package io_port_pkg;

  localparam int NUM_PORTS = 7;
  localparam int PORT_A = 0;
  localparam int PORT_B = 1;
  localparam int PORT_C = 2;
  localparam int PORT_D = 3;
  localparam int PORT_E = 4;
  localparam int PORT_F = 5;
  localparam int PORT_G = 6;

  typedef logic [NUM_PORTS-1:0][7:0] port_bytes_type;

  typedef enum logic [1:0] {
    BUS_MUX8,
    BUS_PAGE,
    BUS_NONMUX
  } bus_kind_type;

  // Host address bits 15:8 that select the I/O register space
  localparam logic [7:0] IO_SPACE_PAGE = 8'hB0;

  // Register groups: offset bits 7:3 pick the group, bits 2:0 the port
  localparam logic [4:0] GRP_DATA_IN = 5'h00;
  localparam logic [4:0] GRP_DATA_OUT = 5'h01;
  localparam logic [4:0] GRP_DIRECTION = 5'h02;
  localparam logic [4:0] GRP_DRIVE = 5'h03;
  localparam logic [4:0] GRP_MODE = 5'h04;

  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] FULL_PORT = 8'hFF;
  localparam logic [7:0] NARROW_PORT = 8'h0F;

  // Controller registers seen over APB
  localparam logic [11:0] CTL_ADDRESS = 12'h000;
  localparam logic [11:0] CTL_WDATA = 12'h004;
  localparam logic [11:0] CTL_COMMAND = 12'h008;
  localparam logic [11:0] CTL_STATUS = 12'h00C;
  localparam logic [11:0] CTL_RDATA = 12'h010;
  localparam int CMD_START_BIT = 0;
  localparam int CMD_READ_BIT = 1;
  localparam int STATUS_BUSY_BIT = 0;

endpackage

// ---- hw/io_port_bus_if.sv ----
// Host bus between the microcontroller end and the port block
`timescale 1ns/1ps
`default_nettype none
interface io_port_bus_if;
  logic address_latch_strobe;
  logic io_select;
  logic wr;
  logic rd;
  logic [15:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport device (
    input address_latch_strobe,
    input io_select,
    input wr,
    input rd,
    input addr,
    input wdata,
    output rdata
  );

  modport host (
    output address_latch_strobe,
    output io_select,
    output wr,
    output rd,
    output addr,
    output wdata,
    input rdata
  );
endinterface
`default_nettype wire

// ---- hw/io_port_host_ctrl.sv ----
// Host end: APB-controlled engine that runs host bus cycles to the port block
`timescale 1ns/1ps
`default_nettype none
module io_port_host_ctrl
  import io_port_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output var logic [31:0] prdata,
  output var logic pready,
  output var logic pslverr,
  io_port_bus_if.host bus
);
  import io_port_pkg::*;

  typedef enum logic [1:0] {
    H_IDLE,
    H_LATCH,
    H_STROBE,
    H_SETTLE
  } host_state_type;

  typedef struct packed {
    host_state_type fsm;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic is_read;
    logic busy;
    logic pready;
    logic [31:0] prdata;
    logic ale;
    logic io_select;
    logic wr;
    logic rd;
  } host_reg_type;

  host_reg_type st;
  host_reg_type next_st;

  logic access;
  assign access = psel && penable;

  always_comb begin
    next_st = st;
    next_st.pready = access && !st.pready;
    if (access && !st.pready) begin
      case (paddr)
        CTL_ADDRESS: next_st.prdata = {16'h0000, st.addr};
        CTL_WDATA: next_st.prdata = {24'h000000, st.wdata};
        CTL_STATUS: next_st.prdata = {31'h0, st.busy};
        CTL_RDATA: next_st.prdata = {24'h000000, st.rdata};
        default: next_st.prdata = 32'h00000000;
      endcase
    end
    if (access && st.pready && pwrite) begin
      case (paddr)
        CTL_ADDRESS: next_st.addr = pwdata[15:0];
        CTL_WDATA: next_st.wdata = pwdata[7:0];
        CTL_COMMAND: begin
          // A command while a cycle runs is dropped
          if (pwdata[CMD_START_BIT] && !st.busy) begin
            next_st.busy = 1'b1;
            next_st.is_read = pwdata[CMD_READ_BIT];
          end
        end
        default: next_st.busy = st.busy;
      endcase
    end
    case (st.fsm)
      H_IDLE: begin
        if (next_st.busy && !st.busy) begin
          next_st.fsm = H_LATCH;
          next_st.ale = 1'b1;
          next_st.io_select = 1'b1;
        end
      end
      H_LATCH: begin
        next_st.ale = 1'b0;
        next_st.rd = st.is_read;
        next_st.wr = !st.is_read;
        next_st.fsm = H_STROBE;
      end
      H_STROBE: begin
        next_st.rd = 1'b0;
        next_st.wr = 1'b0;
        next_st.fsm = H_SETTLE;
      end
      H_SETTLE: begin
        if (st.is_read) begin
          next_st.rdata = bus.rdata;
        end
        next_st.io_select = 1'b0;
        next_st.busy = 1'b0;
        next_st.fsm = H_IDLE;
      end
      default: next_st.fsm = H_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.fsm <= H_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = 1'b0;
  assign bus.address_latch_strobe = st.ale;
  assign bus.io_select = st.io_select;
  assign bus.wr = st.wr;
  assign bus.rd = st.rd;
  assign bus.addr = st.addr;
  assign bus.wdata = st.wdata;

endmodule // io_port_host_ctrl
`default_nettype wire

// ---- verification/io_port_bus_assertions.sv ----
// Checker on the host bus that joins the two ends
`timescale 1ns/1ps
`default_nettype none
module io_port_bus_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic address_latch_strobe,
  input wire logic io_select,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  latch_then_strobe_a: assert property (address_latch_strobe |=>
    !address_latch_strobe && io_select && (rd ^ wr)) else $error("strobe missing");
  strobe_single_a: assert property ((rd || wr) |=> !rd && !wr)
    else $error("strobe too long");
  strobe_cause_a: assert property ((rd || wr) |-> io_select && $past(address_latch_strobe))
    else $error("stray strobe");
  select_span_a: assert property ($rose(io_select) |-> io_select[*3] ##[1:2] !io_select)
    else $error("select length");
  select_latch_a: assert property ($rose(io_select) |-> address_latch_strobe)
    else $error("select without latch");
  addr_hold_a: assert property (io_select && !$rose(io_select) |-> $stable(addr))
    else $error("address moved");
  rdata_hold_a: assert property (!$past(rd) |-> $stable(rdata))
    else $error("read data moved");
  idle_quiet_a: assert property (!io_select |-> !rd && !wr && !address_latch_strobe)
    else $error("strobe while idle");
endmodule // io_port_bus_assertions
`default_nettype wire

// ---- verification/io_port_mode_config_tb.sv ----
// Self-checking bench: APB host engine driving the port block
`timescale 1ns/1ps
`default_nettype none
module io_port_mode_config_tb;
  import io_port_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed, rv;
  port_bytes_type pin_in, pin_out, pin_oe_n, logic_oe, array_in, array_addr;
  // Pin 7 of port A is a high address input
  localparam port_bytes_type ADDR_IN = 56'h80;
  logic [2:0][7:0] logic_out;
  logic [7:0] slew_fast, dr, dt;
  int err_total, checked, cyc;
  io_port_bus_if bus_if();
  io_port_host_ctrl io_port_host_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bus(bus_if.host));
  io_port_mode_config #(.ADDR_IN_MASK(ADDR_IN)) io_port_mode_config_inst (.pclk(pclk),
    .presetn(presetn),
    .bus(bus_if.device), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .logic_out(logic_out), .logic_oe(logic_oe), .array_in(array_in), .array_addr(array_addr),
    .slew_fast(slew_fast));
  io_port_bus_assertions io_port_bus_assertions_inst (.pclk(pclk), .presetn(presetn),
    .address_latch_strobe(bus_if.address_latch_strobe), .io_select(bus_if.io_select),
    .wr(bus_if.wr), .rd(bus_if.rd), .addr(bus_if.addr), .wdata(bus_if.wdata),
    .rdata(bus_if.rdata));
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  // Writable bits of a register group on a port
  function automatic logic [7:0] wmask(input logic [4:0] g, input int p);
    if (g == GRP_MODE) return (p >= PORT_E) ? FULL_PORT : REG_RESET;
    if (g == GRP_DRIVE && p == PORT_F) return REG_RESET;
    if (g == GRP_DRIVE) return (p == PORT_D) ? NARROW_PORT : FULL_PORT;
    return ((p == PORT_D) ? NARROW_PORT : FULL_PORT) & ~ADDR_IN[p];
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    checked++;
    if (seen !== want) begin
      err_total++;
      $display("MISMATCH %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // One host bus cycle run by the engine; read data lands in rv
  task automatic host(input logic w, input logic [7:0] off, input logic [7:0] d);
    apb(1'b1, CTL_ADDRESS, {16'h0000, IO_SPACE_PAGE, off});
    apb(1'b1, CTL_WDATA, {24'h000000, d});
    apb(1'b1, CTL_COMMAND, {30'h0, ~w, 1'b1});
    rv = 32'h00000001;
    while (rv[STATUS_BUSY_BIT] !== 1'b0) apb(1'b0, CTL_STATUS, 32'h00000000);
    apb(1'b0, CTL_RDATA, 32'h00000000);
  endtask
  task automatic setp(input int p, input logic [7:0] r, t, v, m);
    host(1'b1, {GRP_DIRECTION, p[2:0]}, r);
    host(1'b1, {GRP_DATA_OUT, p[2:0]}, t);
    host(1'b1, {GRP_DRIVE, p[2:0]}, v);
    host(1'b1, {GRP_MODE, p[2:0]}, m);
  endtask
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 90000) begin
      err_total++;
      finish_test();
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    pin_in = '0;
    logic_out = '0;
    logic_oe = '0;
    seed = 5;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int g = 0; g < 5; g++) for (int p = 0; p < 7; p++) begin
      host(1'b0, {g[4:0], p[2:0]}, 8'h00);
      check(rv[7:0], REG_RESET);
    end
    for (int g = 1; g < 5; g++) for (int p = 0; p < 7; p++) begin
      dt = rnd() & ((g[4:0] == GRP_DIRECTION) ? ~ADDR_IN[p] : FULL_PORT);
      host(1'b1, {g[4:0], p[2:0]}, dt);
      host(1'b0, {g[4:0], p[2:0]}, 8'h00);
      check(rv[7:0], dt & wmask(g[4:0], p));
    end
    @(posedge pclk);
    for (int p = 0; p < 7; p++) pin_in[p] <= rnd() | ((p == PORT_A) ? ADDR_IN[PORT_A] : 8'h00);
    logic_out <= {rnd(), rnd(), rnd()};
    for (int p = 0; p < 7; p++) begin
      dr = rnd() & ~ADDR_IN[p];
      dt = rnd();
      setp(p, dr, dt, 8'h00, 8'h00);
      dr = dr & wmask(GRP_DIRECTION, p);
      check(pin_oe_n[p] & wmask(GRP_DIRECTION, p), ~dr & wmask(GRP_DIRECTION, p));
      check(pin_out[p] & dr, dt & dr);
      host(1'b0, {GRP_DATA_IN, p[2:0]}, 8'h00);
      check(rv[7:0], pin_in[p] & wmask(GRP_DIRECTION, p));
    end
    check(array_addr[PORT_A], ADDR_IN[PORT_A]);
    check(array_in[PORT_A], pin_in[PORT_A]);
    pin_in[PORT_A] <= 8'h00;
    host(1'b0, 8'h00, 8'h00);
    check(array_addr[PORT_A], 8'h00);
    dt = rnd();
    setp(PORT_A, ~ADDR_IN[PORT_A], dt, 8'hFF, 8'h00);
    check(pin_oe_n[PORT_A], dt | ADDR_IN[PORT_A]);
    check(pin_out[PORT_A], 8'h00);
    setp(PORT_C, 8'h00, 8'h00, dt, 8'h00);
    check(slew_fast, dt);
    setp(PORT_E, 8'h00, 8'h00, 8'h00, 8'hFF);
    setp(PORT_G, 8'hFF, 8'h00, 8'h00, 8'hFF);
    host(1'b0, 8'h19, 8'h00);
    check(pin_out[PORT_G], 8'h19);
    check(pin_oe_n[PORT_G], 8'h00);
    check(pin_oe_n[PORT_E], 8'hFF);
    logic_oe[PORT_E] <= 8'hFF;
    repeat (3) @(posedge pclk);
    check(pin_oe_n[PORT_E], 8'h00);
    check(pin_out[PORT_E], 8'h19);
    host(1'b1, {GRP_DIRECTION, 3'd7}, 8'hFF);
    host(1'b0, {GRP_DIRECTION, 3'd7}, 8'h00);
    check(rv[7:0], 8'h00);
    apb(1'b0, 12'h100, 32'h00000000);
    check(rv[7:0], 8'h00);
    check({7'h00, pslverr}, 8'h00);
    finish_test();
  end
endmodule // io_port_mode_config_tb
`default_nettype wire
